// [verilog/interrupt_accept_return.sv]
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "intr_accept_defs.svh"

module interrupt_accept_return
  import intr_accept_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] irq_src_i,
  input  wire logic        instr_last_i,
  input  wire logic        software_trap_irq_i,
  input  wire logic        illegal_opcode_irq_i,
  input  wire logic        return_from_maskable_i,
  input  wire logic        return_from_nonmaskable_i,
  input  wire logic        disable_irq_instr_i,
  input  wire logic        enable_irq_instr_i,
  input  wire logic [7:0]  program_status_byte_i,
  input  wire logic [15:0] pc_i,
  input  wire logic [15:0] sp_i,
  output mem_port_t        mem_o,
  input  wire logic [7:0]  mem_rdata_i,
  output ctx_load_t        ctx_o,
  output logic             busy_o,
  output logic             master_irq_enable_o,
  input  wire logic        single_chip_i,
  input  wire fetch_info_t fetch_i,
  input  wire logic [7:0]  fetch_data_i,
  output logic      [7:0]  fetch_data_o,
  output logic             fetch_trap_reset_o
);

  seq_state_t  state_r;
  seq_state_t  state_nxt;
  mem_port_t   mem_r;
  mem_port_t   mem_nxt;
  ctx_load_t   ctx_r;
  ctx_load_t   ctx_nxt;
  logic [15:0] pending_r;
  logic [15:0] pending_nxt;
  logic [15:0] src_en_r;
  logic        master_en_r;
  logic        nm_service_r;
  logic        resample_r;
  logic        ret_nm_r;
  logic [15:0] sp_r;
  logic [15:0] pc_r;
  logic [15:0] vec_r;
  logic [3:0]  src_r;
  logic [7:0]  lo_r;
  logic [7:0]  hi_r;
  logic        ack_r;
  logic [7:0]  rdat_r;
  logic [7:0]  rdat_nxt;
  logic [7:0]  fetch_data_r;
  logic        trap_reset_r;
  logic [15:0] elig;
  logic [15:0] accept_clr;
  logic [15:0] sw_clr;
  logic [15:0] vector;
  logic [3:0]  sel_idx;
  logic [7:0]  stack_status;
  logic [5:0]  wb_idx;
  logic        idle;
  logic        trap_req;
  logic        ret_req;
  logic        sample;
  logic        start_trap;
  logic        start_src;
  logic        start_acc;
  logic        start_ret;
  logic        wb_hit;
  logic        wb_wr;

  // Lowest index wins among eligible latched sources.
  function automatic logic [3:0] first_src(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Eligibility: latches 2 and 3 are non-maskable, the rest need both enables.
  assign elig = pending_r & {src_en_r[15:`FIRST_MASKABLE]
                & {12{master_en_r}}, 2'b11, 2'b00};
  assign idle       = (state_r == IDLE);
  assign trap_req   = software_trap_irq_i | illegal_opcode_irq_i;
  assign ret_req    = return_from_maskable_i | return_from_nonmaskable_i;
  assign sample     = instr_last_i | resample_r;
  // Trap opcode and illegal opcode bypass the sampling point and nesting.
  assign start_trap = idle & trap_req;
  assign start_ret  = idle & ~trap_req & ret_req;
  assign start_src  = idle & ~trap_req & ~ret_req & sample & (|elig);
  assign start_acc  = start_trap | start_src;
  assign sel_idx    = first_src(elig);
  assign vector     = start_trap ? `VEC_TRAP
                    : (`VEC_TOP - {11'h000, sel_idx, 1'b0});
  assign accept_clr = start_src ? (16'h0001 << sel_idx) : 16'h0000;
  // The stacked status carries master enable as sampled before the clear.
  assign stack_status = {program_status_byte_i[7:1], master_en_r};

  // Wishbone decode: word aligned, low byte lane carries the 8-bit registers.
  assign wb_idx = wb_adr_i[7:2];
  assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_wr  = wb_hit & wb_we_i & wb_sel_i[0];
  assign sw_clr = {(wb_wr && wb_idx == `OFS_PENDING_HIGH) ? ~wb_dat_i[7:0] : 8'h00,
                   (wb_wr && wb_idx == `OFS_PENDING_LOW) ? ~wb_dat_i[7:0] : 8'h00};

  // Per-latch next value; a new request wins over any clear in the same cycle.
  for (genvar i = 0; i < 16; i++) begin : g_latch
    if (i < `FIRST_LATCH) begin : g_none
      assign pending_nxt[i] = 1'b0;
    end else begin : g_bit
      assign pending_nxt[i] = irq_src_i[i]
                            | (pending_r[i] & ~accept_clr[i] & ~sw_clr[i]);
    end
  end

  // Pending latch storage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_r <= `RST_PENDING;
    end else begin
      pending_r <= pending_nxt;
    end
  end

  // Per-source enable flags, software written only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_en_r <= `RST_ENABLE;
    end else if (wb_wr && wb_idx == `OFS_IRQ_ENABLE_LOW) begin
      src_en_r[7:`FIRST_MASKABLE] <= wb_dat_i[7:`FIRST_MASKABLE];
    end else if (wb_wr && wb_idx == `OFS_IRQ_ENABLE_HIGH) begin
      src_en_r[15:8] <= wb_dat_i[7:0];
    end
  end

  // Master enable: acceptance beats return, which beats the instructions and bus.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_en_r <= `RST_MASTER_EN;
    end else if (start_acc) begin
      master_en_r <= 1'b0;
    end else if (state_r == POP_LOAD) begin
      master_en_r <= mem_rdata_i[`POS_MASTER_EN];
    end else if (disable_irq_instr_i) begin
      master_en_r <= 1'b0;
    end else if (enable_irq_instr_i) begin
      master_en_r <= 1'b1;
    end else if (wb_wr && wb_idx == `OFS_IRQ_ENABLE_LOW) begin
      master_en_r <= wb_dat_i[`POS_MASTER_EN];
    end
  end

  // Sequencer state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Step order of the acceptance and return sequences.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      IDLE: begin
        if (start_acc) begin
          state_nxt = PUSH_STAT;
        end else if (start_ret) begin
          state_nxt = POP_PCL;
        end
      end
      PUSH_STAT: state_nxt = PUSH_PCH;
      PUSH_PCH:  state_nxt = PUSH_PCL;
      PUSH_PCL:  state_nxt = VEC_LO;
      VEC_LO:    state_nxt = VEC_HI;
      VEC_HI:    state_nxt = VEC_LOAD;
      VEC_LOAD:  state_nxt = IDLE;
      POP_PCL:   state_nxt = POP_PCH;
      POP_PCH:   state_nxt = POP_STAT;
      POP_STAT:  state_nxt = POP_LOAD;
      POP_LOAD:  state_nxt = IDLE;
      default:   state_nxt = IDLE;
    endcase
  end

  // Context captured when a sequence starts; it stays stable throughout.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_r     <= 16'h0000;
      pc_r     <= 16'h0000;
      vec_r    <= 16'h0000;
      src_r    <= 4'h0;
      ret_nm_r <= 1'b0;
    end else if (start_acc || start_ret) begin
      sp_r     <= sp_i;
      pc_r     <= pc_i;
      vec_r    <= vector;
      ret_nm_r <= return_from_nonmaskable_i;
      if (start_acc) begin
        src_r <= start_trap ? 4'h1 : sel_idx;
      end
    end
  end

  // Bytes read back from the vector table or the stack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lo_r <= 8'h00;
      hi_r <= 8'h00;
    end else if (state_r == VEC_HI || state_r == POP_PCH) begin
      lo_r <= mem_rdata_i;
    end else if (state_r == POP_STAT) begin
      hi_r <= mem_rdata_i;
    end
  end

  // Memory requests; read data returns in the cycle after a request is shown.
  always_comb begin
    mem_nxt = '0;
    case (state_r)
      IDLE: begin
        if (start_acc) begin
          mem_nxt = '{1'b1, 1'b1, sp_i, stack_status};
        end else if (start_ret) begin
          mem_nxt = '{1'b1, 1'b0, sp_i + 16'h0001, 8'h00};
        end
      end
      PUSH_STAT: mem_nxt = '{1'b1, 1'b1, sp_r - 16'h0001, pc_r[15:8]};
      PUSH_PCH:  mem_nxt = '{1'b1, 1'b1, sp_r - 16'h0002, pc_r[7:0]};
      PUSH_PCL:  mem_nxt = '{1'b1, 1'b0, vec_r, 8'h00};
      VEC_LO:    mem_nxt = '{1'b1, 1'b0, vec_r + 16'h0001, 8'h00};
      POP_PCL:   mem_nxt = '{1'b1, 1'b0, sp_r + 16'h0002, 8'h00};
      POP_PCH:   mem_nxt = '{1'b1, 1'b0, sp_r + `FRAME_BYTES, 8'h00};
      default:   mem_nxt = '0;
    endcase
  end

  // Load strobes into the core; the status byte is left alone on acceptance.
  always_comb begin
    ctx_nxt = '0;
    case (state_r)
      VEC_LOAD: begin
        ctx_nxt.pc_we = 1'b1;
        ctx_nxt.pc    = {mem_rdata_i, lo_r};
        ctx_nxt.sp_we = 1'b1;
        ctx_nxt.sp    = sp_r - `FRAME_BYTES;
      end
      POP_LOAD: begin
        ctx_nxt.pc_we     = 1'b1;
        ctx_nxt.pc        = {hi_r, lo_r};
        ctx_nxt.status_we = 1'b1;
        ctx_nxt.status    = mem_rdata_i;
        ctx_nxt.sp_we     = 1'b1;
        ctx_nxt.sp        = sp_r + `FRAME_BYTES;
      end
      default: ctx_nxt = '0;
    endcase
  end

  // Registered memory request and load strobes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_r <= '0;
      ctx_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      ctx_r <= ctx_nxt;
    end
  end

  // A completed return opens a sampling point in the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resample_r <= 1'b0;
    end else begin
      resample_r <= (state_r == POP_LOAD);
    end
  end

  // Non-maskable service status; an illegal opcode may nest over it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nm_service_r <= 1'b0;
    end else if (start_trap || (start_src && sel_idx < `FIRST_MASKABLE)) begin
      nm_service_r <= 1'b1;
    end else if (state_r == POP_LOAD && ret_nm_r) begin
      nm_service_r <= 1'b0;
    end
  end

  // Fetch guard: in single-chip mode, non-existent space reads as the trap opcode.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_data_r <= 8'h00;
      trap_reset_r <= 1'b0;
    end else begin
      if (fetch_i.valid && fetch_i.nonexist && single_chip_i) begin
        fetch_data_r <= `SW_TRAP_OPCODE;
      end else begin
        fetch_data_r <= fetch_data_i;
      end
      trap_reset_r <= fetch_i.valid & fetch_i.ram_sfr;
    end
  end

  // Register read mux; unmapped indexes read zero.
  always_comb begin
    rdat_nxt = 8'h00;
    case (wb_idx)
      `OFS_IRQ_ENABLE_LOW:
        rdat_nxt = {src_en_r[7:`FIRST_MASKABLE], 3'b000, master_en_r};
      `OFS_IRQ_ENABLE_HIGH: rdat_nxt = src_en_r[15:8];
      `OFS_PENDING_LOW:     rdat_nxt = pending_r[7:0];
      `OFS_PENDING_HIGH:    rdat_nxt = pending_r[15:8];
      `OFS_ACCEPT_STATUS:   rdat_nxt = {src_r, 2'b00, nm_service_r, ~idle};
      default:              rdat_nxt = 8'h00;
    endcase
  end

  // Wishbone slave: ack one cycle after the strobe, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 8'h00;
    end else begin
      ack_r <= wb_hit;
      if (wb_hit) begin
        rdat_r <= rdat_nxt;
      end
    end
  end

  assign wb_ack_o            = ack_r;
  assign wb_dat_o            = {24'h000000, rdat_r};
  assign mem_o               = mem_r;
  assign ctx_o               = ctx_r;
  assign busy_o              = ~idle;
  assign master_irq_enable_o = master_en_r;
  assign fetch_data_o        = fetch_data_r;
  assign fetch_trap_reset_o  = trap_reset_r;

  // Checks of the acceptance and return behaviour.
  localparam int LAT_CYC = `LATENCY_CYC;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence push_seq;
    mem_r.we && mem_r.addr == sp_r && mem_r.wdata[0] == $past(master_en_r)
    ##1 mem_r.we && mem_r.addr == sp_r - 16'h0001 && mem_r.wdata == pc_r[15:8]
    ##1 mem_r.we && mem_r.addr == sp_r - 16'h0002 && mem_r.wdata == pc_r[7:0];
  endsequence

  sequence vec_seq;
    !mem_r.we && mem_r.addr == vec_r ##1 !mem_r.we && mem_r.addr == vec_r + 16'h0001;
  endsequence

  ef_reset_a: assert property (disable iff (1'b0) rst_i |=> src_en_r == 16'h0000)
    else $error("enable flags not cleared by reset");
  imf_clear_a: assert property (start_acc |=> !master_en_r)
    else $error("master enable not cleared on acceptance");
  latch_clear_a: assert property (start_src && !irq_src_i[sel_idx]
    |=> !pending_r[$past(sel_idx)])
    else $error("accepted latch not cleared");
  push_order_a: assert property (start_acc |=> push_seq ##1 vec_seq)
    else $error("stacking order or addresses wrong");
  vec_load_a: assert property (start_acc |-> ##7 ctx_r.pc_we && !ctx_r.status_we
    && ctx_r.sp == sp_r - `FRAME_BYTES)
    else $error("vector load or stack pointer wrong");
  mask_block_a: assert property (start_src && sel_idx >= `FIRST_MASKABLE
    |-> $past(1'b1) && master_en_r && src_en_r[sel_idx])
    else $error("maskable source accepted while blocked");
  ret_restore_a: assert property (start_ret |-> ##5 ctx_r.pc_we && ctx_r.status_we
    && ctx_r.sp == sp_r + `FRAME_BYTES && master_en_r == ctx_r.status[0])
    else $error("return did not restore context");
  trap_start_a: assert property (idle && trap_req |=> state_r == PUSH_STAT
    && vec_r == `VEC_TRAP)
    else $error("trap did not start at shared vector");
  sample_point_a: assert property (idle && !trap_req && !ret_req && instr_last_i
    && (|elig) |-> ##[1:LAT_CYC] state_r == PUSH_STAT)
    else $error("enabled request not accepted at sampling point");
  fetch_ff_a: assert property (fetch_i.valid && fetch_i.nonexist && single_chip_i
    |=> fetch_data_o == `SW_TRAP_OPCODE)
    else $error("non-existent fetch did not return trap opcode");
  trap_reset_a: assert property (fetch_i.valid && fetch_i.ram_sfr
    |=> fetch_trap_reset_o)
    else $error("RAM or register fetch gave no trap reset");

endmodule
`default_nettype wire

// [verilog/intr_accept_defs.svh]
`ifndef INTR_ACCEPT_DEFS_SVH
`define INTR_ACCEPT_DEFS_SVH

// Register indexes; the byte address on the bus is four times the index.
`define OFS_IRQ_ENABLE_LOW  6'h3A
`define OFS_IRQ_ENABLE_HIGH 6'h3B
`define OFS_PENDING_LOW     6'h3C
`define OFS_PENDING_HIGH    6'h3D
`define OFS_ACCEPT_STATUS   6'h30

// Field positions.
`define POS_MASTER_EN       0
`define POS_STAT_BUSY       0
`define POS_STAT_NM         1
`define FIRST_LATCH         2
`define FIRST_MASKABLE      4

// Reset values.
`define RST_ENABLE          16'h0000
`define RST_PENDING         16'h0000
`define RST_MASTER_EN       1'b0

// Vectors, trap opcode and stack frame size.
`define VEC_TOP             16'hFFFE
`define VEC_TRAP            16'hFFFC
`define SW_TRAP_OPCODE      8'hFF
`define FRAME_BYTES         16'h0003

// Worst-case acceptance latency, in system clock periods, in nanoseconds and in cycles.
`define CLK_PERIOD_NS       10
`define LATENCY_TC          38
`define LATENCY_NS          (`LATENCY_TC * `CLK_PERIOD_NS)
`define LATENCY_CYC         (`LATENCY_NS / `CLK_PERIOD_NS)

`endif

// [verilog/intr_accept_pkg.sv]
`default_nettype none
package intr_accept_pkg;

  // Steps of the acceptance and return sequences.
  typedef enum logic [3:0] {
    IDLE,
    PUSH_STAT,
    PUSH_PCH,
    PUSH_PCL,
    VEC_LO,
    VEC_HI,
    VEC_LOAD,
    POP_PCL,
    POP_PCH,
    POP_STAT,
    POP_LOAD
  } seq_state_t;

  // Byte-wide stack and vector memory request.
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_port_t;

  // One-cycle load strobes into the core's program counter, status and SP.
  typedef struct packed {
    logic        pc_we;
    logic [15:0] pc;
    logic        status_we;
    logic [7:0]  status;
    logic        sp_we;
    logic [15:0] sp;
  } ctx_load_t;

  // Instruction fetch classification from the core's address decoder.
  typedef struct packed {
    logic valid;
    logic nonexist;
    logic ram_sfr;
  } fetch_info_t;

endpackage
`default_nettype wire

// [testbench/core_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Byte memory standing in for the core's stack and vector table.
module core_mem_model
  import intr_accept_pkg::*;
(
  input  wire logic      clk_i,
  input  wire mem_port_t mem_i,
  output logic     [7:0] rdata_o
);
  logic [7:0] ram [0:65535];

  // Fill every byte from its address so vectors are known to the bench.
  initial begin
    for (int a = 0; a < 65536; a++) begin
      ram[a] = a[7:0] ^ a[15:8] ^ 8'h3C;
    end
    rdata_o = 8'h00;
  end

  // Read data shows one cycle after a read; otherwise it keeps toggling.
  always @(posedge clk_i) begin
    if (mem_i.req && mem_i.we) begin
      ram[mem_i.addr] <= mem_i.wdata;
    end
    rdata_o <= (mem_i.req && !mem_i.we) ? ram[mem_i.addr] : ~rdata_o;
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "intr_accept_defs.svh"
// Drives the acceptance block like a core and checks its sequences.
module tb_top
  import intr_accept_pkg::*;
;
  localparam logic [15:0] PC0 = 16'h1234;
  localparam logic [15:0] SP0 = 16'h01F0;
  localparam logic [7:0]  PROGRAM_STATUS_BYTE = 8'hA6;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, sc = 1'b0;
  logic [7:0]  adr = 8'h00, rd, fd = 8'h00, fdo, q;
  logic [31:0] dat = 32'h0, rdat;
  logic [6:0]  ev = 7'h00;
  logic [15:0] src = 16'h0000, sp = SP0;
  mem_port_t   mem_o;
  ctx_load_t   ctx_o;
  logic        busy_o, master_irq_enable_o, ftr;
  fetch_info_t fi = '0;
  int          err_count = 0, tests_run = 0;

  // System clock at 100 MHz.
  always #5 clk_i = ~clk_i;

  interrupt_accept_return u_interrupt_accept_return (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_src_i(src),
    .instr_last_i(ev[0]), .software_trap_irq_i(ev[1]),
    .illegal_opcode_irq_i(ev[2]), .return_from_maskable_i(ev[3]),
    .return_from_nonmaskable_i(ev[4]), .disable_irq_instr_i(ev[5]),
    .enable_irq_instr_i(ev[6]), .program_status_byte_i(PROGRAM_STATUS_BYTE), .pc_i(PC0),
    .sp_i(sp), .mem_o(mem_o), .mem_rdata_i(rd), .ctx_o(ctx_o),
    .busy_o(busy_o), .master_irq_enable_o(master_irq_enable_o),
    .single_chip_i(sc), .fetch_i(fi), .fetch_data_i(fd),
    .fetch_data_o(fdo), .fetch_trap_reset_o(ftr));

  core_mem_model u_core_mem_model (.clk_i(clk_i), .mem_i(mem_o),
                                   .rdata_o(rd));

  // Prints the counts and the verdict, then stops the run.
  task conclude;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compares one observed value with its expected value.
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Bench's own copy of the memory fill pattern.
  function automatic logic [7:0] mv(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction

  // One classic bus cycle; the request holds until ack is sampled.
  task wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w;
    adr <= {idx, 2'b00}; dat <= {24'h0, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    q = rdat[7:0];
    if (n == 20) begin
      err_count++;
      conclude();
    end
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  // One-cycle pulse of core events and source requests.
  task pulse(input logic [6:0] m, input logic [15:0] s);
    @(posedge clk_i);
    ev <= m; src <= s;
    @(posedge clk_i);
    ev <= 7'h00; src <= 16'h0000;
  endtask

  // Watches ten cycles and expects no acceptance to start.
  task no_accept;
    logic b;
    b = 1'b0;
    repeat (10) begin
      @(negedge clk_i);
      b = b | busy_o;
    end
    chk("busy_idle", b, 0);
  endtask

  // Follows one acceptance: stack frame, vector load and timing.
  task check_accept(input logic [15:0] vec, input logic [7:0] stat);
    int n, w, nb;
    logic [7:0] wd [3];
    w = 0; nb = 0;
    wd[0] = stat; wd[1] = PC0[15:8]; wd[2] = PC0[7:0];
    for (n = 1; n <= 40; n++) begin
      @(negedge clk_i);
      if (busy_o === 1'b1 && nb == 0) nb = n;
      if (mem_o.req === 1'b1 && mem_o.we === 1'b1) begin
        chk("push_addr", mem_o.addr, SP0 - w);
        if (w < 3) chk("push_data", mem_o.wdata, wd[w]);
        w++;
      end
      if (ctx_o.pc_we === 1'b1) break;
    end
    if (n > 40) begin
      err_count++;
      conclude();
    end
    chk("push_count", w, 3);
    chk("vec_pc", ctx_o.pc, {mv(vec + 16'h1), mv(vec)});
    chk("acc_sp", ctx_o.sp, SP0 - 16'h0003);
    chk("acc_imf", master_irq_enable_o, 0);
    chk("latency", (nb > 0 && nb <= `LATENCY_TC), 1);
  endtask

  // Runs a return with the stack pointer at the frame just built.
  task do_return(input logic [6:0] m, input logic [7:0] stat,
                 input logic [15:0] pc);
    int n;
    @(posedge clk_i);
    sp <= SP0 - 16'h0003; ev <= m;
    @(posedge clk_i);
    sp <= SP0; ev <= 7'h00;
    for (n = 0; n < 20; n++) begin
      @(negedge clk_i);
      if (ctx_o.pc_we === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      conclude();
    end
    chk("ret_pc", ctx_o.pc, pc);
    chk("ret_sp", ctx_o.sp, SP0);
    chk("ret_stat", ctx_o.status, stat);
    chk("ret_imf", master_irq_enable_o, stat[0]);
  endtask

  // Fetch filtering: empty space reads as the trap opcode.
  task fetch_test;
    @(posedge clk_i);
    sc <= 1'b1; fi <= 3'b110; fd <= 8'h12;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("fetch_ff", fdo, `SW_TRAP_OPCODE);
    @(posedge clk_i);
    fi <= 3'b101;
    @(posedge clk_i);
    fi <= 3'b000;
    @(negedge clk_i);
    chk("trap_rst", ftr, 1);
  endtask

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `OFS_IRQ_ENABLE_LOW, 8'h00);
    chk("en_low_rst", q, 8'h00);
    wb(1'b0, `OFS_IRQ_ENABLE_HIGH, 8'h00);
    chk("en_high_rst", q, 8'h00);
    wb(1'b0, 6'h10, 8'h00);
    chk("unmapped", q, 8'h00);
    pulse(7'h40, 16'h0000);
    pulse(7'h00, 16'h0040);
    pulse(7'h01, 16'h0000);
    no_accept();
    pulse(7'h20, 16'h0000);
    wb(1'b1, `OFS_IRQ_ENABLE_LOW, 8'h20);
    wb(1'b0, `OFS_IRQ_ENABLE_LOW, 8'h00);
    chk("en_low_wr", q, 8'h20);
    pulse(7'h00, 16'h0020);
    pulse(7'h01, 16'h0000);
    no_accept();
    pulse(7'h40, 16'h0000);
    pulse(7'h01, 16'h0000);
    check_accept(`VEC_TOP - 16'h000A, PROGRAM_STATUS_BYTE | 8'h01);
    wb(1'b0, `OFS_PENDING_LOW, 8'h00);
    chk("latch_clr", q, 8'h40);
    pulse(7'h00, 16'h0020);
    do_return(7'h08, PROGRAM_STATUS_BYTE | 8'h01, PC0);
    check_accept(`VEC_TOP - 16'h000A, PROGRAM_STATUS_BYTE | 8'h01);
    do_return(7'h10, PROGRAM_STATUS_BYTE | 8'h01, PC0);
    pulse(7'h00, 16'h0020);
    pulse(7'h03, 16'h0000);
    check_accept(`VEC_TRAP, PROGRAM_STATUS_BYTE | 8'h01);
    pulse(7'h04, 16'h0000);
    check_accept(`VEC_TRAP, PROGRAM_STATUS_BYTE);
    wb(1'b0, `OFS_ACCEPT_STATUS, 8'h00);
    chk("nm_status", q, 8'h12);
    do_return(7'h10, PROGRAM_STATUS_BYTE, PC0);
    no_accept();
    // Non-maskable latch 2: nest prep, then rewrite the stacked return address.
    pulse(7'h00, 16'h0004);
    pulse(7'h01, 16'h0000);
    check_accept(`VEC_TOP - 16'h0004, PROGRAM_STATUS_BYTE);
    wb(1'b1, `OFS_IRQ_ENABLE_LOW, 8'h00);
    pulse(7'h40, 16'h0000);
    pulse(7'h01, 16'h0000);
    no_accept();
    u_core_mem_model.ram[SP0 - 16'h0002] = 8'h56;
    u_core_mem_model.ram[SP0 - 16'h0001] = 8'h04;
    do_return(7'h10, PROGRAM_STATUS_BYTE, 16'h0456);
    no_accept();
    fetch_test();
    conclude();
  end

  // Cuts a hang short.
  initial begin
    #200000;
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
